// file: rtl/init_sequencer_pwm_gate_control.sv
// power-up init sequencer with run/timebase/gpio pin control and two gate channels
// How it works
// - start init when both internal supplies good
// - reset or restore command reruns full init
// - failed ram test restricts bus addresses
// - failed ram test sets persistent memory fault
// - failed ram test blocks nonvolatile memory access
// - failed ram test holds run, timebase low
// - reset at fault address retests, resumes on pass
// - gate outputs off throughout init
// - init holds run/timebase low, gpio released
// - init scans resistors, copies nonvolatile memory
// - all resistor pins open: memory only
// - ignore-pins flag: memory except address
// - address pins not open set address part
// - init completes about 35 ms after supply
// - timebase low until input above turn-on
// - telemetry valid 90 ms after init
// - clock edge resets latch, comparator sets it
// - peak limit kills high, reverse kills low
// - repeated peak trips raise overcurrent fault
// - low side on while high off
// - discontinuous mode: low off at zero current
// - 12-bit code scaled by 5.5 or 2.75
`timescale 1ns/1ps
`default_nettype none
module init_sequencer_pwm_gate_control #(
  parameter int INIT_CYCLES = init_seq_pkg::INIT_CYCLES,
  parameter int TELEM_CYCLES = init_seq_pkg::TELEM_CYCLES,
  parameter int NVM_AW = 3
) (
  input wire logic clock,
  input wire logic sys_rst,
  // analog supervisors (asynchronous)
  input wire logic supply3v3Ok,
  input wire logic supply2v5Ok,
  input wire logic vinAboveOn,
  // decoded bus commands (same clock)
  input wire logic deviceResetCommand,
  input wire logic restoreAllCommand,
  input wire logic [6:0] commandAddr,
  // configuration resistor readout (same clock)
  input wire logic [init_seq_pkg::CFG_PINS-1:0] cfgPinOpen,
  input wire logic [init_seq_pkg::CFG_PINS-1:0][11:0] cfgPinCode,
  input wire logic [1:0] addressSelectOpen,
  input wire logic [3:0] addressSelectCode,
  // nonvolatile memory read port, data one cycle after enable
  output logic nvmReadEn,
  output logic [NVM_AW-1:0] nvmAddr,
  input wire logic [15:0] nvmReadData,
  // open-drain pins: oe low means driving low
  input wire logic [1:0] runPinIn,
  output logic [1:0] runPinOut,
  output logic [1:0] runPinOeN,
  output logic shareClkOut,
  output logic shareClkOeN,
  input wire logic [1:0] gpioDriveLow,
  output logic [1:0] gpioOut,
  output logic [1:0] gpioOeN,
  // channel sense and gate commands
  input wire init_seq_pkg::chan_sense_t [1:0] chanSense,
  input wire logic [1:0] dcmMode,
  output init_seq_pkg::gate_cmd_t [1:0] gateCmd,
  output logic [1:0] overcurrentFault,
  // status
  output logic initDone,
  output logic memFaultFlag,
  output logic busRestricted,
  output logic commandAccepted,
  output logic [6:0] deviceAddr,
  output logic telemetryValid,
  output logic [1:0][12:0] regTargetQuarterMv,
  output logic [11:0] freqCode,
  output logic [11:0] phaseCode
);
  localparam int TW = $clog2(INIT_CYCLES + TELEM_CYCLES + 1);

  init_seq_pkg::init_state_t state;
  logic [2:0] sup1;
  logic [2:0] sup2;
  logic [1:0] run1;
  logic [1:0] run2;
  logic lockoutOk;
  logic restart;
  logic addrAllowed;
  logic [TW-1:0] initTimer;
  logic [TW-1:0] telemTimer;
  logic [15:0] cmdMem [init_seq_pkg::CFG_WORDS];
  logic [NVM_AW:0] copyIdx;
  logic copyPending;
  logic [NVM_AW-1:0] copyAddr;
  logic [init_seq_pkg::CFG_PINS-1:0] pinOpen;
  logic [init_seq_pkg::CFG_PINS-1:0][11:0] pinCode;
  logic [1:0] aselOpen;
  logic [3:0] aselCode;
  logic bistStart;
  logic bistBusy;
  logic bistDone;
  logic bistFail;
  logic [1:0] chanEnable;
  logic useResistors;

  // scale a 12-bit dac code to the regulated target in quarter millivolts
  function automatic logic [12:0] scaleTarget(input logic [15:0] word);
    logic [15:0] prod;
    prod = 16'(word[11:0]) * 16'(init_seq_pkg::SCALE_MUL);
    if (word[init_seq_pkg::RANGE_BIT]) begin
      return 13'(prod >> init_seq_pkg::SCALE_SHIFT_R1);
    end
    return 13'(prod >> init_seq_pkg::SCALE_SHIFT_R0);
  endfunction

  // supervisors and run pins cross in through two flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sup1 <= '0;
      sup2 <= '0;
      run1 <= '0;
      run2 <= '0;
    end else begin
      sup1 <= {vinAboveOn, supply2v5Ok, supply3v3Ok};
      sup2 <= sup1;
      run1 <= runPinIn;
      run2 <= run1;
    end
  end

  assign lockoutOk = sup2[0] && sup2[1];

  // after a failed self test only the fault and global addresses answer
  always_comb begin
    addrAllowed = 1'b1;
    if (memFaultFlag) begin
      addrAllowed = (commandAddr == init_seq_pkg::FAULT_ADDR) ||
                    (commandAddr == init_seq_pkg::GLOBAL_ADDR_A) ||
                    (commandAddr == init_seq_pkg::GLOBAL_ADDR_B);
    end
  end

  assign restart = (deviceResetCommand || restoreAllCommand) && addrAllowed &&
                   state != init_seq_pkg::ST_LOCKOUT;

  // main sequence; a command restarts it from the self test
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= init_seq_pkg::ST_LOCKOUT;
    end else if (!lockoutOk) begin
      state <= init_seq_pkg::ST_LOCKOUT;
    end else if (restart) begin
      state <= init_seq_pkg::ST_SELFTEST;
    end else begin
      unique case (state)
        init_seq_pkg::ST_LOCKOUT: begin
          state <= init_seq_pkg::ST_SELFTEST;
        end
        init_seq_pkg::ST_SELFTEST: begin
          if (bistDone) begin
            state <= bistFail ? init_seq_pkg::ST_FAULT : init_seq_pkg::ST_SCAN;
          end
        end
        init_seq_pkg::ST_FAULT: begin
          state <= init_seq_pkg::ST_FAULT;
        end
        init_seq_pkg::ST_SCAN: begin
          state <= init_seq_pkg::ST_COPY;
        end
        init_seq_pkg::ST_COPY: begin
          if (!copyPending && copyIdx == (NVM_AW + 1)'(init_seq_pkg::CFG_WORDS)) begin
            state <= init_seq_pkg::ST_SETTLE;
          end
        end
        init_seq_pkg::ST_SETTLE: begin
          if (initTimer >= TW'(INIT_CYCLES)) begin
            state <= init_seq_pkg::ST_WAIT_VIN;
          end
        end
        init_seq_pkg::ST_WAIT_VIN: begin
          if (sup2[2]) begin
            state <= init_seq_pkg::ST_RUN;
          end
        end
        init_seq_pkg::ST_RUN: begin
          state <= init_seq_pkg::ST_RUN;
        end
      endcase
    end
  end

  // init time measured from supply lockout release
  always_ff @(posedge clock) begin
    if (sys_rst || state == init_seq_pkg::ST_LOCKOUT || restart) begin
      initTimer <= '0;
    end else if (state != init_seq_pkg::ST_WAIT_VIN && state != init_seq_pkg::ST_RUN &&
                 initTimer < TW'(INIT_CYCLES)) begin
      initTimer <= initTimer + 1'b1;
    end
  end

  // telemetry round-robin pass must finish before readback is trusted
  always_ff @(posedge clock) begin
    if (sys_rst || !lockoutOk || restart ||
        !(state == init_seq_pkg::ST_WAIT_VIN || state == init_seq_pkg::ST_RUN)) begin
      telemTimer <= '0;
      telemetryValid <= 1'b0;
    end else if (telemTimer < TW'(TELEM_CYCLES)) begin
      telemTimer <= telemTimer + 1'b1;
    end else begin
      telemetryValid <= 1'b1;
    end
  end

  // self test launch pulse on entry
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bistStart <= 1'b0;
    end else begin
      bistStart <= (state == init_seq_pkg::ST_LOCKOUT && lockoutOk) || restart;
    end
  end

  ram_self_test u_bist (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(bistStart),
    .busy(bistBusy),
    .done(bistDone),
    .fail(bistFail)
  );

  // fault flag holds until a later self test passes; a new failure wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      memFaultFlag <= 1'b0;
    end else if (bistDone && bistFail) begin
      memFaultFlag <= 1'b1;
    end else if (bistDone) begin
      memFaultFlag <= 1'b0;
    end
  end

  assign busRestricted = memFaultFlag;

  // command acknowledge, registered
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      commandAccepted <= 1'b0;
    end else begin
      commandAccepted <= restart;
    end
  end

  // resistor pins sampled once per init
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinOpen <= '1;
      pinCode <= '0;
      aselOpen <= 2'h3;
      aselCode <= 4'h0;
    end else if (state == init_seq_pkg::ST_SCAN) begin
      pinOpen <= cfgPinOpen;
      pinCode <= cfgPinCode;
      aselOpen <= addressSelectOpen;
      aselCode <= addressSelectCode;
    end
  end

  assign copyAddr = copyIdx[NVM_AW-1:0];

  // nvm copy: one read every other cycle, data lands one cycle later; never in fault
  always_ff @(posedge clock) begin
    if (sys_rst || state != init_seq_pkg::ST_COPY || memFaultFlag) begin
      copyIdx <= '0;
      copyPending <= 1'b0;
      nvmReadEn <= 1'b0;
      nvmAddr <= '0;
    end else begin
      copyPending <= nvmReadEn;
      if (copyIdx != (NVM_AW + 1)'(init_seq_pkg::CFG_WORDS) && !nvmReadEn) begin
        nvmReadEn <= 1'b1;
        nvmAddr <= copyAddr;
      end else begin
        nvmReadEn <= 1'b0;
        if (nvmReadEn) begin
          copyIdx <= copyIdx + 1'b1;
        end
      end
    end
  end

  // working command memory; cleared when a fresh init begins
  always_ff @(posedge clock) begin
    if (sys_rst || bistStart) begin
      for (int i = 0; i < init_seq_pkg::CFG_WORDS; i++) begin
        cmdMem[i] <= init_seq_pkg::CFG_RESET;
      end
    end else if (copyPending) begin
      cmdMem[nvmAddr] <= nvmReadData;
    end
  end

  // resistors count only if some pin is fitted and the ignore flag is clear
  assign useResistors = !(&pinOpen) &&
    !cmdMem[init_seq_pkg::WORD_GLOBAL][init_seq_pkg::IGNORE_PINS_BIT];

  // configuration outputs, resistor value where fitted and allowed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regTargetQuarterMv <= '0;
      freqCode <= 12'h000;
      phaseCode <= 12'h000;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (useResistors && !pinOpen[c]) begin
          regTargetQuarterMv[c] <= scaleTarget({cmdMem[init_seq_pkg::WORD_VOUT0 + c][15:12],
                                                pinCode[c]});
        end else begin
          regTargetQuarterMv[c] <= scaleTarget(cmdMem[init_seq_pkg::WORD_VOUT0 + c]);
        end
      end
      freqCode <= (useResistors && !pinOpen[2]) ? pinCode[2] :
                  cmdMem[init_seq_pkg::WORD_FREQ][11:0];
      phaseCode <= (useResistors && !pinOpen[3]) ? pinCode[3] :
                   cmdMem[init_seq_pkg::WORD_PHASE][11:0];
    end
  end

  // address pins override the low nibble unless both are open, ignore flag or not
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      deviceAddr <= 7'h00;
    end else if (memFaultFlag) begin
      deviceAddr <= init_seq_pkg::FAULT_ADDR;
    end else if (aselOpen != 2'h3) begin
      deviceAddr <= {cmdMem[init_seq_pkg::WORD_ADDR][6:4], aselCode};
    end else begin
      deviceAddr <= cmdMem[init_seq_pkg::WORD_ADDR][6:0];
    end
  end

  // pin control: run and timebase held low until running, gpio released during init
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      runPinOut <= 2'h0;
      runPinOeN <= 2'h0;
      shareClkOut <= 1'b0;
      shareClkOeN <= 1'b0;
      gpioOut <= 2'h0;
      gpioOeN <= 2'h3;
      initDone <= 1'b0;
    end else begin
      runPinOut <= 2'h0;
      shareClkOut <= 1'b0;
      gpioOut <= 2'h0;
      initDone <= state == init_seq_pkg::ST_WAIT_VIN || state == init_seq_pkg::ST_RUN;
      if (state == init_seq_pkg::ST_RUN && !restart) begin
        runPinOeN <= 2'h3;
        shareClkOeN <= 1'b1;
        gpioOeN <= ~gpioDriveLow;
      end else begin
        runPinOeN <= 2'h0;
        shareClkOeN <= 1'b0;
        gpioOeN <= (state == init_seq_pkg::ST_WAIT_VIN) ? ~gpioDriveLow : 2'h3;
      end
    end
  end

  // gates run only after init with the run pin high
  assign chanEnable = (state == init_seq_pkg::ST_RUN) ? run2 : 2'h0;

  for (genvar g = 0; g < 2; g++) begin : g_chan
    pwm_gate_channel u_chan (
      .clock(clock),
      .sys_rst(sys_rst),
      .sense(chanSense[g]),
      .enable(chanEnable[g]),
      .dcmMode(dcmMode[g]),
      .gate(gateCmd[g]),
      .ocFault(overcurrentFault[g])
    );
  end
endmodule
`default_nettype wire

// file: rtl/init_seq_pkg.sv
// constants, types and states shared by the init sequencer and gate control
package init_seq_pkg;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int INIT_TIME_MS = 35;
  localparam int TELEM_TIME_MS = 90;
  localparam int INIT_CYCLES = (CLK_HZ / 1000) * INIT_TIME_MS;
  localparam int TELEM_CYCLES = (CLK_HZ / 1000) * TELEM_TIME_MS;
  // serial bus addresses kept while the memory test has failed
  localparam logic [6:0] FAULT_ADDR = 7'h7c;
  localparam logic [6:0] GLOBAL_ADDR_A = 7'h5a;
  localparam logic [6:0] GLOBAL_ADDR_B = 7'h5b;
  // working memory word layout
  localparam int CFG_WORDS = 8;
  localparam int WORD_GLOBAL = 0;
  localparam int WORD_ADDR = 1;
  localparam int WORD_VOUT0 = 2;
  localparam int WORD_VOUT1 = 3;
  localparam int WORD_FREQ = 4;
  localparam int WORD_PHASE = 5;
  localparam int IGNORE_PINS_BIT = 6;
  localparam int RANGE_BIT = 12;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // configuration resistor pin order: vout0, vout1, freq, phase
  localparam int CFG_PINS = 4;
  // setpoint scaling: dac lsb 0.0625 mV, range 0 x5.5, range 1 x2.75
  localparam logic [3:0] SCALE_MUL = 4'hb;
  localparam int SCALE_SHIFT_R0 = 3;
  localparam int SCALE_SHIFT_R1 = 4;
  // consecutive peak trips that raise an overcurrent fault
  localparam int OC_TRIP_LIMIT = 4;
  // memory self test
  localparam int RAM_WORDS = 64;
  localparam int RAM_WIDTH = 16;
  localparam logic [15:0] RAM_PATTERN = 16'h5a3c;

  typedef struct packed {
    logic hsOn;
    logic lsOn;
  } gate_cmd_t;

  typedef struct packed {
    logic clkPin;
    logic pwmTrip;
    logic peakTrip;
    logic revTrip;
  } chan_sense_t;

  typedef enum logic [2:0] {
    ST_LOCKOUT = 3'b000,
    ST_SELFTEST = 3'b001,
    ST_FAULT = 3'b010,
    ST_SCAN = 3'b011,
    ST_COPY = 3'b100,
    ST_SETTLE = 3'b101,
    ST_WAIT_VIN = 3'b110,
    ST_RUN = 3'b111
  } init_state_t;

  typedef enum logic [1:0] {
    BT_WRITE = 2'b00,
    BT_CHECK = 2'b01,
    BT_WRITE_INV = 2'b10,
    BT_CHECK_INV = 2'b11
  } bist_phase_t;
endpackage

// file: rtl/ram_self_test.sv
// working ram with a write/compare march self test
`timescale 1ns/1ps
`default_nettype none
module ram_self_test #(
  parameter int WORDS = init_seq_pkg::RAM_WORDS,
  parameter int WIDTH = init_seq_pkg::RAM_WIDTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  output logic busy,
  output logic done,
  output logic fail
);
  localparam int AW = $clog2(WORDS);
  logic [WIDTH-1:0] mem [WORDS];
  logic [AW-1:0] addr;
  init_seq_pkg::bist_phase_t phase;

  // address-dependent pattern so stuck address lines show up
  function automatic logic [WIDTH-1:0] pattern(input logic [AW-1:0] a, input logic inv);
    logic [WIDTH-1:0] p;
    p = init_seq_pkg::RAM_PATTERN[WIDTH-1:0] ^ WIDTH'(a);
    return inv ? ~p : p;
  endfunction

  // march: write all, check all, write inverse, check inverse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      addr <= '0;
      phase <= init_seq_pkg::BT_WRITE;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        fail <= 1'b0;
        addr <= '0;
        phase <= init_seq_pkg::BT_WRITE;
      end else if (busy) begin
        if (phase == init_seq_pkg::BT_WRITE || phase == init_seq_pkg::BT_WRITE_INV) begin
          mem[addr] <= pattern(addr, phase[1]);
        end else if (mem[addr] != pattern(addr, phase[1])) begin
          fail <= 1'b1;
        end
        addr <= addr + 1'b1;
        if (addr == AW'(WORDS - 1)) begin
          addr <= '0;
          phase <= init_seq_pkg::bist_phase_t'(phase + 2'b01);
          if (phase == init_seq_pkg::BT_CHECK_INV) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/pwm_gate_channel.sv
// per-channel pwm latch and high/low side gate command
`timescale 1ns/1ps
`default_nettype none
module pwm_gate_channel #(
  parameter int TRIP_LIMIT = init_seq_pkg::OC_TRIP_LIMIT
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire init_seq_pkg::chan_sense_t sense,
  input wire logic enable,
  input wire logic dcmMode,
  output init_seq_pkg::gate_cmd_t gate,
  output logic ocFault
);
  init_seq_pkg::chan_sense_t s1;
  init_seq_pkg::chan_sense_t s2;
  logic clkPrev;
  logic latch;
  logic lsBlock;
  logic tripSeen;
  logic [$clog2(TRIP_LIMIT+1)-1:0] tripCount;
  logic clkEdge;
  logic next_latch;
  logic next_lsBlock;

  // comparator and clock pins come from the analog side
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      clkPrev <= 1'b0;
    end else begin
      s1 <= sense;
      s2 <= s1;
      clkPrev <= s2.clkPin;
    end
  end

  assign clkEdge = s2.clkPin && !clkPrev;

  // clock edge resets, comparator sets; peak limit overrides the set
  always_comb begin
    next_latch = latch;
    next_lsBlock = lsBlock;
    if (clkEdge) begin
      next_latch = 1'b0;
      next_lsBlock = 1'b0;
    end else if (s2.pwmTrip) begin
      next_latch = 1'b1;
      next_lsBlock = 1'b0;
    end
    if (s2.peakTrip) begin
      next_latch = 1'b0;
    end
    if (s2.revTrip && !next_latch) begin
      next_lsBlock = 1'b1;
    end
    if (!dcmMode && !s2.revTrip && !s2.peakTrip && !clkEdge && s2.pwmTrip) begin
      next_lsBlock = 1'b0;
    end
    if (!enable) begin
      next_latch = 1'b0;
      next_lsBlock = 1'b1;
    end
  end

  // gate outputs straight from flops, never both on
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      latch <= 1'b0;
      lsBlock <= 1'b1;
      gate <= '0;
    end else begin
      latch <= next_latch;
      lsBlock <= next_lsBlock;
      gate.hsOn <= next_latch;
      gate.lsOn <= !next_latch && !next_lsBlock;
    end
  end

  // one trip per switching cycle counts; a clean cycle clears the run
  always_ff @(posedge clock) begin
    if (sys_rst || !enable) begin
      tripSeen <= 1'b0;
      tripCount <= '0;
      ocFault <= 1'b0;
    end else begin
      if (s2.peakTrip) begin
        tripSeen <= 1'b1;
      end
      if (clkEdge) begin
        tripSeen <= 1'b0;
        if (!tripSeen) begin
          tripCount <= '0;
        end else if (tripCount != TRIP_LIMIT[$bits(tripCount)-1:0]) begin
          tripCount <= tripCount + 1'b1;
        end
      end
      if (tripCount == TRIP_LIMIT[$bits(tripCount)-1:0]) begin
        ocFault <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/init_seq_checker.sv
// port assertions for the init sequencer and gate control
`timescale 1ns/1ps
`default_nettype none
module init_seq_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic supply3v3Ok,
  input wire logic supply2v5Ok,
  input wire logic vinAboveOn,
  input wire logic deviceResetCommand,
  input wire logic restoreAllCommand,
  input wire logic nvmReadEn,
  input wire logic [1:0] runPinOeN,
  input wire logic shareClkOeN,
  input wire logic [1:0] gpioOeN,
  input wire init_seq_pkg::gate_cmd_t [1:0] gateCmd,
  input wire logic [1:0] overcurrentFault,
  input wire logic initDone,
  input wire logic memFaultFlag,
  input wire logic busRestricted,
  input wire logic commandAccepted,
  input wire logic [6:0] deviceAddr,
  input wire logic telemetryValid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // two cycles of init so a registered lag at a supply drop is not flagged
  AST_GATES_OFF_INIT: assert property (!initDone [*2] |-> gateCmd == '0)
    else $error("gate on during init");
  AST_PINS_LOW_INIT: assert property (!initDone [*2] |-> runPinOeN == 2'b00 && !shareClkOeN)
    else $error("run or timebase released during init");
  AST_GPIO_HIZ_INIT: assert property (!initDone [*2] |-> gpioOeN == 2'b11)
    else $error("gpio driven during init");
  AST_SHARE_ONLY_DONE: assert property (shareClkOeN |-> initDone)
    else $error("timebase released before init done");
  AST_SHARE_NEEDS_VIN: assert property ($rose(shareClkOeN) |-> $past(vinAboveOn, 2))
    else $error("timebase released without input voltage");
  AST_NO_SHOOT: assert property (!(gateCmd[0].hsOn && gateCmd[0].lsOn) && !(gateCmd[1].hsOn && gateCmd[1].lsOn))
    else $error("both switches on");
  AST_RESTRICT_FLAG: assert property (busRestricted == memFaultFlag)
    else $error("bus restriction differs from fault flag");
  AST_FAULT_ADDR: assert property (memFaultFlag |-> deviceAddr == init_seq_pkg::FAULT_ADDR)
    else $error("fault address wrong");
  AST_FAULT_NO_NVM: assert property (memFaultFlag |-> !nvmReadEn)
    else $error("memory read while faulted");
  AST_FAULT_PINS_LOW: assert property (memFaultFlag |-> runPinOeN == 2'b00 && !shareClkOeN)
    else $error("pins released while faulted");
  AST_CMD_RESTART: assert property (initDone && !busRestricted && (deviceResetCommand || restoreAllCommand)
    |=> commandAccepted ##[0:2] !initDone)
    else $error("command did not restart init");
  AST_SUPPLY_LOST: assert property (!(supply3v3Ok && supply2v5Ok) [*5] |-> !initDone)
    else $error("init done without supplies");
  AST_TELEM_AFTER_INIT: assert property ($rose(telemetryValid) |-> initDone)
    else $error("telemetry valid before init");
  cover property (commandAccepted);
  cover property ($rose(shareClkOeN));
  cover property ($rose(overcurrentFault[0]));
endmodule
bind init_sequencer_pwm_gate_control init_seq_checker init_seq_checker_i (.*);
`default_nettype wire

// file: tb/nvm_model.sv
// nonvolatile memory model on the sequencer's read port
`timescale 1ns/1ps
`default_nettype none
module nvm_model (
  input wire logic clock,
  input wire logic nvmReadEn,
  input wire logic [2:0] nvmAddr,
  output logic [15:0] nvmReadData
);
  logic [15:0] mem [8];
  initial nvmReadData = 16'h0000;
  // data stands one cycle, then flips so a late sample shows up
  always @(posedge clock) begin
    if (nvmReadEn) begin
      nvmReadData <= mem[nvmAddr];
    end else begin
      nvmReadData <= ~nvmReadData;
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the init sequencer and gate control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int INIT = 400;
  logic clock, sys_rst, supply3v3Ok, supply2v5Ok, vinAboveOn, deviceResetCommand, restoreAllCommand;
  logic nvmReadEn, shareClkOut, shareClkOeN, initDone, memFaultFlag, busRestricted, commandAccepted;
  logic telemetryValid, prevDone;
  logic [6:0] commandAddr, deviceAddr;
  logic [3:0] cfgPinOpen, addressSelectCode;
  logic [3:0][11:0] cfgPinCode;
  logic [1:0] addressSelectOpen, runPinOut, runPinOeN, gpioDriveLow, gpioOut, gpioOeN, dcmMode, overcurrentFault;
  logic [1:0] runPinIn;
  logic [2:0] nvmAddr;
  logic [15:0] nvmReadData;
  init_seq_pkg::chan_sense_t [1:0] chanSense;
  init_seq_pkg::gate_cmd_t [1:0] gateCmd;
  logic [1:0][12:0] regTargetQuarterMv;
  logic [11:0] freqCode, phaseCode;
  logic [31:0] seed;
  logic [31:0] expQ[$];
  int fails, n_checks, cnt;
  // released run pins float up through the pull-up
  assign runPinIn = runPinOeN;
  init_sequencer_pwm_gate_control #(.INIT_CYCLES(INIT), .TELEM_CYCLES(300)) init_sequencer_pwm_gate_control_i (.*);
  nvm_model nvm_model_i (.clock(clock), .nvmReadEn(nvmReadEn), .nvmAddr(nvmAddr), .nvmReadData(nvmReadData));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // fresh memory image and pins, expected fields queued for the monitor
  task automatic prep(input logic ign, input logic [1:0] aOpen, input logic [3:0] pOpen);
    logic [47:0] pc;
    logic [11:0] f;
    logic [11:0] v;
    logic [6:0] a;
    logic [3:0] c;
    for (int i = 0; i < 8; i++) nvm_model_i.mem[i] = 16'(rnd());
    nvm_model_i.mem[0][6] = ign;
    pc = 48'({rnd(), rnd()});
    c = 4'(rnd());
    {cfgPinCode, cfgPinOpen, addressSelectOpen, addressSelectCode} <= {pc, pOpen, aOpen, c};
    f = (!ign && !pOpen[2]) ? pc[35:24] : nvm_model_i.mem[4][11:0];
    v = (!ign && !pOpen[0]) ? pc[11:0] : nvm_model_i.mem[2][11:0];
    a = nvm_model_i.mem[1][6:0];
    if (aOpen != 2'b11) a[3:0] = c;
    // 5.5x is 11/8 of the code, 2.75x is 11/16
    expQ.push_back({a, f, 13'(nvm_model_i.mem[2][12] ? (v * 11) >> 4 : (v * 11) >> 3)});
  endtask
  task automatic waitDone();
    cnt = 0;
    while (initDone !== 1'b1 && cnt < 3000) begin
      cyc(1);
      cnt++;
    end
  endtask
  task automatic gate(input logic [3:0] s, input int n, input logic [1:0] g);
    chanSense <= {2{s}};
    cyc(n);
    chanSense <= '0;
    cyc(5);
    check("gate", gateCmd, {2{g}}); // both channels against the pair
  endtask
  // result monitor: each init completion takes the oldest queued note
  always @(posedge clock) begin
    prevDone <= initDone;
    if (initDone === 1'b1 && prevDone === 1'b0) begin
      check("config", {deviceAddr, freqCode, regTargetQuarterMv[0]}, expQ.pop_front()); // loaded
    end
  end
  initial begin
    cyc(20000);
    fails++;
    close_out();
  end
  initial begin
    seed = 32'h68c8afcc;
    prevDone = 1'b0;
    {sys_rst, supply3v3Ok, supply2v5Ok, vinAboveOn, deviceResetCommand, restoreAllCommand} <= 6'h30;
    {chanSense, dcmMode, gpioDriveLow, commandAddr} <= {8'h00, 2'b01, 2'b10, init_seq_pkg::FAULT_ADDR};
    {cfgPinOpen, cfgPinCode, addressSelectOpen, addressSelectCode} <= '0;
    cyc(20);
    sys_rst <= 1'b0;
    prep(1'b0, 2'b11, 4'b0000); // pins win over memory
    cyc(50);
    check("lockout", {initDone, nvmReadEn, gpioOeN}, 4'h3);
    supply2v5Ok <= 1'b1;
    waitDone();
    check("initTime", cnt >= INIT && cnt <= INIT + 8, 1);
    cyc(20);
    check("shareHeld", {shareClkOeN, gpioOeN}, 3'b001);
    vinAboveOn <= 1'b1;
    cyc(6);
    check("shareRel", shareClkOeN, 1);
    cyc(250);
    check("telemEarly", telemetryValid, 0);
    cyc(40);
    check("telemLate", telemetryValid, 1);
    gate(4'h4, 3, 2'b10); // comparator trip sets latch
    gate(4'h8, 3, 2'b01); // clock edge resets latch
    gate(4'h0, 30, 2'b01); // low side keeps on
    gate(4'h4, 3, 2'b10);
    gate(4'h2, 1, 2'b01); // peak limit
    gate(4'h1, 2, 2'b00); // reverse limit, zero current
    gate(4'h4, 3, 2'b10);
    for (int k = 0; k < 3; k++) gate(4'ha, 3, 2'b01); // three tripped clock cycles stay below limit
    check("ocShort", overcurrentFault, 2'b00);
    gate(4'ha, 3, 2'b01); // fourth tripped clock cycle
    check("ocLong", overcurrentFault, 2'b11);
    for (int k = 0; k < 2; k++) begin
      prep(k == 0, k == 0 ? 2'b00 : 2'b11, k == 0 ? 4'b0000 : 4'b1111);
      cyc(2);
      {deviceResetCommand, restoreAllCommand} <= k == 0 ? 2'b10 : 2'b01;
      cyc(1);
      {deviceResetCommand, restoreAllCommand} <= 2'b00;
      cyc(1);
      check("accepted", commandAccepted, 1);
      cyc(4);
      check("restart", {initDone, runPinOeN, shareClkOeN}, 0);
      waitDone();
      check("rerun", cnt < 3000, 1);
    end
    cyc(10);
    prep(1'b0, 2'b11, 4'b1111);
    supply3v3Ok <= 1'b0;
    cyc(10);
    check("drop", {initDone, runPinOeN, shareClkOeN, gateCmd}, 0);
    supply3v3Ok <= 1'b1;
    waitDone();
    check("initTime2", cnt >= INIT && cnt <= INIT + 8, 1);
    close_out();
  end
endmodule
`default_nettype wire
